// *** meter_event_interrupt_mask.sv ***
// Event interrupt mask, second status register and phase source register
//
// Register access over Avalon-MM is this design's own decision.
`timescale 1ns/100ps
`default_nettype none
module meter_event_interrupt_mask
  import meter_irq_pkg::*;
#(
  parameter bit HAS_FUNDAMENTAL = 1'b1,
  parameter bit HAS_MISMATCH = 1'b1
) (
  // Clock, reset and enable
  input wire logic mclk,
  input wire logic resetn,
  input wire logic clkEn,
  // Register bus
  input wire avmm_req_t busReq,
  output logic [31:0] readdata,
  output logic waitrequest,
  // Detector events
  input wire event_in_t events,
  // Interrupt request
  output logic irq
);

  logic [31:0] maskReg;
  logic [31:0] compMaskReg;
  logic [31:0] statusReg;
  logic [31:0] compStatusReg;
  logic [15:0] phaseSrcReg;
  logic [31:0] readdataReg;
  logic ackReg;
  logic startedReg;
  logic irqReg;

  // Bus decode
  wire [15:0] wordIndex = busReq.address[ADDR_W-1:2];
  wire busActive = busReq.read | busReq.write;
  wire hitMask = (wordIndex == MASK_INDEX);
  wire hitCompMask = (wordIndex == COMP_MASK_INDEX);
  wire hitStatus = (wordIndex == STATUS_INDEX);
  wire hitCompStatus = (wordIndex == COMP_STATUS_INDEX);
  wire hitPhaseSrc = (wordIndex == PHASE_SRC_INDEX);
  wire writeTaken = clkEn & busReq.write & ackReg;
  wire readTaken = clkEn & busReq.read & ~ackReg;
  wire [31:0] byteMask = {{8{busReq.byteenable[3]}}, {8{busReq.byteenable[2]}},
                          {8{busReq.byteenable[1]}}, {8{busReq.byteenable[0]}}};
  wire [31:0] writeBits = busReq.writedata & byteMask;

  // One wait cycle, then the answer edge
  assign waitrequest = busActive & ~ackReg;
  assign readdata = readdataReg;
  assign irq = irqReg;

  // event vector mapped onto the status layout
  wire [31:0] eventVec;
  assign eventVec[BIT_NOLOAD_TOTAL] = events.noloadTotal;
  assign eventVec[BIT_NOLOAD_FUND] = events.noloadFund;
  assign eventVec[BIT_NOLOAD_APP] = events.noloadApparent;
  assign eventVec[BIT_VOLT_TIMEOUT+2:BIT_VOLT_TIMEOUT] = events.voltTimeout;
  assign eventVec[BIT_CURR_TIMEOUT+2:BIT_CURR_TIMEOUT] = events.currTimeout;
  assign eventVec[BIT_VOLT_CROSS+2:BIT_VOLT_CROSS] = events.voltCross;
  assign eventVec[BIT_CURR_CROSS+2:BIT_CURR_CROSS] = events.currCross;
  assign eventVec[BIT_RESET_DONE] = clkEn & ~startedReg;
  assign eventVec[BIT_SAG] = events.sag;
  assign eventVec[BIT_OVERCURRENT] = events.overcurrent;
  assign eventVec[BIT_OVERVOLTAGE] = events.overvoltage;
  assign eventVec[BIT_PHASE_ORDER] = events.phaseOrder;
  assign eventVec[BIT_MISMATCH] = events.mismatch;
  assign eventVec[22:21] = 2'h0;
  assign eventVec[BIT_CURR_PEAK] = events.currPeakEnd;
  assign eventVec[BIT_VOLT_PEAK] = events.voltPeakEnd;
  assign eventVec[BIT_SIGNATURE] = events.signatureChange;
  assign eventVec[31:26] = 6'h00;

  wire [31:0] variantGate = MASK_WRITABLE & ~(32'(!HAS_FUNDAMENTAL) << BIT_NOLOAD_FUND)
                            & ~(32'(!HAS_MISMATCH) << BIT_MISMATCH) & ~(32'h1 << BIT_RESET_DONE);
  wire [31:0] effMask = maskReg & variantGate;

  // Write one to clear, set wins over clear
  wire [31:0] statusClear = (writeTaken & hitStatus) ? writeBits : ZERO_WORD;
  wire [31:0] compClear = (writeTaken & hitCompStatus) ? writeBits : ZERO_WORD;
  wire [31:0] compEvent = {14'h0000, events.dspCycleDone, 17'h0_0000};
  wire [31:0] status_next = (statusReg & ~statusClear) | eventVec;
  wire [31:0] compStatus_next = (compStatusReg & ~compClear) | compEvent;

  // phase sources held until the owning flag is written to clear, then only a same-cycle event's phase stays
  wire [15:0] srcEvent = {1'b0, events.sag ? events.sagPhase : 3'h0,
                          events.overvoltage ? events.overvoltagePhase : 3'h0,
                          3'h0, events.overcurrent ? events.overcurrentPhase : 3'h0, 3'h0};
  wire [15:0] srcKeep = {1'b0, {3{~statusClear[BIT_SAG]}}, {3{~statusClear[BIT_OVERVOLTAGE]}},
                         3'h0, {3{~statusClear[BIT_OVERCURRENT]}}, 3'h0};
  // reserved source bits forced to zero
  wire [15:0] phaseSrc_next = ((phaseSrcReg & srcKeep) | srcEvent) & PHASE_SRC_USED;

  wire [31:0] maskedHits = statusReg & effMask;
  // request combines masked flags, companion flag and reset-complete
  wire irq_next = (|maskedHits) | statusReg[BIT_RESET_DONE]
                  | (compStatusReg[BIT_DSP_DONE] & compMaskReg[BIT_DSP_DONE]);

  // Read multiplexer, unmapped reads zero
  wire [31:0] readMux = hitMask ? maskReg :
                        hitCompMask ? compMaskReg :
                        hitStatus ? statusReg :
                        hitCompStatus ? compStatusReg :
                        hitPhaseSrc ? {16'h0000, phaseSrcReg} : ZERO_WORD;

  // mask write keeps reserved bits at zero
  wire [31:0] mask_next = (writeTaken & hitMask) ?
                          (((maskReg & ~byteMask) | writeBits) & MASK_WRITABLE) : maskReg;
  wire [31:0] compMask_next = (writeTaken & hitCompMask) ?
                              (((compMaskReg & ~byteMask) | writeBits) & COMP_MASK_WRITABLE) : compMaskReg;

  // Bus handshake state
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      ackReg <= 1'b0;
      readdataReg <= ZERO_WORD;
    end else if (clkEn) begin
      ackReg <= busActive & ~ackReg;
      if (readTaken) begin
        readdataReg <= readMux;
      end
    end
  end

  // Registers
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      maskReg <= MASK_RESET;
      compMaskReg <= MASK_RESET;
      statusReg <= STATUS_RESET;
      compStatusReg <= STATUS_RESET;
      phaseSrcReg <= PHASE_SRC_RESET;
      startedReg <= 1'b0;
      irqReg <= 1'b0;
    end else if (clkEn) begin
      maskReg <= mask_next;
      compMaskReg <= compMask_next;
      statusReg <= status_next;
      compStatusReg <= compStatus_next;
      phaseSrcReg <= phaseSrc_next;
      startedReg <= 1'b1;
      irqReg <= irq_next;
    end
  end

  // Checks
  chk_mask_reserved_zero: assert property (@(posedge mclk) disable iff (!resetn)
    (maskReg & ~MASK_WRITABLE) == ZERO_WORD)
    else $error("reserved mask bits are not zero");

  chk_phase_reserved_zero: assert property (@(posedge mclk) disable iff (!resetn)
    (phaseSrcReg & ~PHASE_SRC_USED) == 16'h0000)
    else $error("reserved phase source bits are not zero");

  chk_reset_done_irq: assert property (@(posedge mclk) disable iff (!resetn)
    clkEn && statusReg[BIT_RESET_DONE] |=> irq)
    else $error("reset-complete flag did not raise the interrupt");

  chk_masked_flag_irq: assert property (@(posedge mclk) disable iff (!resetn)
    clkEn && (|(statusReg & maskReg & MASK_WRITABLE & ~(32'h1 << BIT_RESET_DONE)
      & ~(32'(!HAS_FUNDAMENTAL) << BIT_NOLOAD_FUND) & ~(32'(!HAS_MISMATCH) << BIT_MISMATCH))) |=> irq)
    else $error("masked flag did not raise the interrupt");

  chk_quiet_no_irq: assert property (@(posedge mclk) disable iff (!resetn)
    clkEn && ((statusReg & maskReg) == ZERO_WORD) && !statusReg[BIT_RESET_DONE] && !compStatusReg[BIT_DSP_DONE]
    |=> !irq)
    else $error("interrupt raised with nothing enabled");

  chk_event_latches: assert property (@(posedge mclk) disable iff (!resetn)
    clkEn && events.voltCross[0] |=> statusReg[BIT_VOLT_CROSS])
    else $error("zero crossing event was not latched");

  chk_set_beats_clear: assert property (@(posedge mclk) disable iff (!resetn)
    writeTaken && hitStatus && writeBits[BIT_SAG] && events.sag |=> statusReg[BIT_SAG])
    else $error("sag event lost against a clear");

  chk_sag_source: assert property (@(posedge mclk) disable iff (!resetn)
    clkEn && events.sag && events.sagPhase[1] |=> phaseSrcReg[SRC_SAG+1] && statusReg[BIT_SAG])
    else $error("sag source phase not recorded");

  chk_overcurrent_source: assert property (@(posedge mclk) disable iff (!resetn)
    clkEn && events.overcurrent && events.overcurrentPhase[2] |=> phaseSrcReg[SRC_OVERCURRENT+2])
    else $error("overcurrent source phase not recorded");

  chk_overvoltage_source: assert property (@(posedge mclk) disable iff (!resetn)
    clkEn && events.overvoltage && events.overvoltagePhase[0] |=> phaseSrcReg[SRC_OVERVOLTAGE])
    else $error("overvoltage source phase not recorded");

  chk_dsp_done_irq: assert property (@(posedge mclk) disable iff (!resetn)
    clkEn && events.dspCycleDone && compMaskReg[BIT_DSP_DONE] && !(writeTaken && hitCompMask)
    ##1 clkEn |=> irq)
    else $error("DSP cycle done did not raise the interrupt");

  chk_bus_one_wait: assert property (@(posedge mclk) disable iff (!resetn)
    clkEn && busActive && !ackReg |=> !waitrequest || !busActive)
    else $error("bus answer did not come after one wait cycle");

  chk_total_noload_irq: assert property (@(posedge mclk) disable iff (!resetn)
    clkEn && statusReg[BIT_NOLOAD_TOTAL] && maskReg[BIT_NOLOAD_TOTAL] |=> irq)
    else $error("total no-load irq missing");

  chk_fund_noload_irq: assert property (@(posedge mclk) disable iff (!resetn)
    clkEn && HAS_FUNDAMENTAL && statusReg[BIT_NOLOAD_FUND] && maskReg[BIT_NOLOAD_FUND] |=> irq)
    else $error("fundamental no-load irq missing");

  chk_apparent_noload_irq: assert property (@(posedge mclk) disable iff (!resetn)
    clkEn && statusReg[BIT_NOLOAD_APP] && maskReg[BIT_NOLOAD_APP] |=> irq)
    else $error("apparent no-load irq missing");

  chk_volt_timeout_irq: assert property (@(posedge mclk) disable iff (!resetn)
    clkEn && (|(statusReg[BIT_VOLT_TIMEOUT+:3] & maskReg[BIT_VOLT_TIMEOUT+:3])) |=> irq)
    else $error("voltage crossing timeout irq missing");

  chk_curr_timeout_irq: assert property (@(posedge mclk) disable iff (!resetn)
    clkEn && (|(statusReg[BIT_CURR_TIMEOUT+:3] & maskReg[BIT_CURR_TIMEOUT+:3])) |=> irq)
    else $error("current crossing timeout irq missing");

  chk_volt_cross_irq: assert property (@(posedge mclk) disable iff (!resetn)
    clkEn && (|(statusReg[BIT_VOLT_CROSS+:3] & maskReg[BIT_VOLT_CROSS+:3])) |=> irq)
    else $error("voltage crossing irq missing");

  chk_curr_cross_irq: assert property (@(posedge mclk) disable iff (!resetn)
    clkEn && (|(statusReg[BIT_CURR_CROSS+:3] & maskReg[BIT_CURR_CROSS+:3])) |=> irq)
    else $error("current crossing irq missing");

  chk_sag_irq: assert property (@(posedge mclk) disable iff (!resetn)
    clkEn && statusReg[BIT_SAG] && maskReg[BIT_SAG] |=> irq)
    else $error("sag irq missing");

  chk_overcurrent_irq: assert property (@(posedge mclk) disable iff (!resetn)
    clkEn && statusReg[BIT_OVERCURRENT] && maskReg[BIT_OVERCURRENT] |=> irq)
    else $error("overcurrent irq missing");

  chk_overvoltage_irq: assert property (@(posedge mclk) disable iff (!resetn)
    clkEn && statusReg[BIT_OVERVOLTAGE] && maskReg[BIT_OVERVOLTAGE] |=> irq)
    else $error("overvoltage irq missing");

  chk_phase_order_irq: assert property (@(posedge mclk) disable iff (!resetn)
    clkEn && statusReg[BIT_PHASE_ORDER] && maskReg[BIT_PHASE_ORDER] |=> irq)
    else $error("phase order irq missing");

  chk_mismatch_irq: assert property (@(posedge mclk) disable iff (!resetn)
    clkEn && HAS_MISMATCH && statusReg[BIT_MISMATCH] && maskReg[BIT_MISMATCH] |=> irq)
    else $error("neutral mismatch irq missing");

  chk_curr_peak_irq: assert property (@(posedge mclk) disable iff (!resetn)
    clkEn && statusReg[BIT_CURR_PEAK] && maskReg[BIT_CURR_PEAK] |=> irq)
    else $error("current peak irq missing");

  chk_volt_peak_irq: assert property (@(posedge mclk) disable iff (!resetn)
    clkEn && statusReg[BIT_VOLT_PEAK] && maskReg[BIT_VOLT_PEAK] |=> irq)
    else $error("voltage peak irq missing");

  chk_signature_irq: assert property (@(posedge mclk) disable iff (!resetn)
    clkEn && statusReg[BIT_SIGNATURE] && maskReg[BIT_SIGNATURE] |=> irq)
    else $error("signature change irq missing");

  chk_mask_bit15_store: assert property (@(posedge mclk) disable iff (!resetn)
    writeTaken && hitMask && busReq.byteenable[1] |=> maskReg[BIT_RESET_DONE] == $past(busReq.writedata[15]))
    else $error("mask bit 15 not stored");

  chk_reset_done_set: assert property (@(posedge mclk) disable iff (!resetn)
    clkEn && !startedReg |=> statusReg[BIT_RESET_DONE])
    else $error("reset-complete flag not set");

  chk_comp_mask_reserved: assert property (@(posedge mclk) disable iff (!resetn)
    (compMaskReg & ~COMP_MASK_WRITABLE) == ZERO_WORD)
    else $error("reserved companion mask bits set");

  chk_dsp_done_latches: assert property (@(posedge mclk) disable iff (!resetn)
    clkEn && events.dspCycleDone |=> compStatusReg[BIT_DSP_DONE])
    else $error("dsp done flag not latched");

  chk_dsp_gate_irq: assert property (@(posedge mclk) disable iff (!resetn)
    clkEn && compStatusReg[BIT_DSP_DONE] && compMaskReg[BIT_DSP_DONE] |=> irq)
    else $error("dsp done irq missing");

  chk_comp_clear: assert property (@(posedge mclk) disable iff (!resetn)
    writeTaken && hitCompStatus && writeBits[BIT_DSP_DONE] && !events.dspCycleDone
    |=> !compStatusReg[BIT_DSP_DONE])
    else $error("dsp done flag not cleared");

  chk_status_reserved: assert property (@(posedge mclk) disable iff (!resetn)
    (statusReg & ~MASK_WRITABLE) == ZERO_WORD)
    else $error("reserved status bits set");

  chk_status_clear: assert property (@(posedge mclk) disable iff (!resetn)
    writeTaken && hitStatus && writeBits[BIT_VOLT_CROSS] && !events.voltCross[0] |=> !statusReg[BIT_VOLT_CROSS])
    else $error("status flag not cleared");

  chk_sag_latches: assert property (@(posedge mclk) disable iff (!resetn)
    clkEn && events.sag |=> statusReg[BIT_SAG])
    else $error("sag flag not latched");

  chk_noload_latches: assert property (@(posedge mclk) disable iff (!resetn)
    clkEn && events.noloadTotal |=> statusReg[BIT_NOLOAD_TOTAL])
    else $error("no-load flag not latched");

  chk_peak_latches: assert property (@(posedge mclk) disable iff (!resetn)
    clkEn && events.currPeakEnd |=> statusReg[BIT_CURR_PEAK])
    else $error("current peak flag not latched");

  chk_signature_latches: assert property (@(posedge mclk) disable iff (!resetn)
    clkEn && events.signatureChange |=> statusReg[BIT_SIGNATURE])
    else $error("signature flag not latched");

  chk_order_latches: assert property (@(posedge mclk) disable iff (!resetn)
    clkEn && events.phaseOrder |=> statusReg[BIT_PHASE_ORDER])
    else $error("phase order flag not latched");

  chk_mismatch_latches: assert property (@(posedge mclk) disable iff (!resetn)
    clkEn && events.mismatch |=> statusReg[BIT_MISMATCH])
    else $error("mismatch flag not latched");

  chk_source_cleared: assert property (@(posedge mclk) disable iff (!resetn)
    writeTaken && hitStatus && writeBits[BIT_SAG] && !events.sag |=> phaseSrcReg[SRC_SAG+:3] == 3'h0)
    else $error("sag source not cleared with its flag");

  chk_phase_src_readonly: assert property (@(posedge mclk) disable iff (!resetn)
    writeTaken && hitPhaseSrc && !events.sag && !events.overcurrent && !events.overvoltage
    |=> $stable(phaseSrcReg))
    else $error("phase source changed by a write");

  chk_enable_freeze: assert property (@(posedge mclk) disable iff (!resetn)
    !clkEn |=> $stable(irq) && $stable(statusReg) && $stable(maskReg))
    else $error("state moved while clock enable low");

  chk_readdata_hold: assert property (@(posedge mclk) disable iff (!resetn)
    !readTaken |=> $stable(readdata))
    else $error("read data changed without a read");

  for (genvar ph = 0; ph < 3; ph++) begin : g_phase_chk
    chk_sag_each_phase: assert property (@(posedge mclk) disable iff (!resetn)
      clkEn && events.sag && events.sagPhase[ph] |=> phaseSrcReg[SRC_SAG+ph])
      else $error("sag phase bit not set");

    chk_ov_each_phase: assert property (@(posedge mclk) disable iff (!resetn)
      clkEn && events.overvoltage && events.overvoltagePhase[ph] |=> phaseSrcReg[SRC_OVERVOLTAGE+ph])
      else $error("overvoltage phase bit not set");

    chk_oc_each_phase: assert property (@(posedge mclk) disable iff (!resetn)
      clkEn && events.overcurrent && events.overcurrentPhase[ph] |=> phaseSrcReg[SRC_OVERCURRENT+ph])
      else $error("overcurrent phase bit not set");

    chk_vcross_latch: assert property (@(posedge mclk) disable iff (!resetn)
      clkEn && events.voltCross[ph] |=> statusReg[BIT_VOLT_CROSS+ph])
      else $error("voltage crossing flag not latched");

    chk_icross_latch: assert property (@(posedge mclk) disable iff (!resetn)
      clkEn && events.currCross[ph] |=> statusReg[BIT_CURR_CROSS+ph])
      else $error("current crossing flag not latched");

    chk_vtimeout_latch: assert property (@(posedge mclk) disable iff (!resetn)
      clkEn && events.voltTimeout[ph] |=> statusReg[BIT_VOLT_TIMEOUT+ph])
      else $error("voltage timeout flag not latched");

    chk_itimeout_latch: assert property (@(posedge mclk) disable iff (!resetn)
      clkEn && events.currTimeout[ph] |=> statusReg[BIT_CURR_TIMEOUT+ph])
      else $error("current timeout flag not latched");
  end

endmodule
`default_nettype wire

// *** meter_irq_pkg.sv ***
// Register map, field layout and carriers of the event interrupt mask block
package meter_irq_pkg;

  // Register indices (byte address is four times the index)
  localparam logic [15:0] MASK_INDEX = 16'hE50B;
  localparam logic [15:0] PHASE_SRC_INDEX = 16'hE600;
  localparam logic [15:0] STATUS_INDEX = 16'hE503;
  localparam logic [15:0] COMP_MASK_INDEX = 16'hE50A;
  localparam logic [15:0] COMP_STATUS_INDEX = 16'hE502;
  localparam int ADDR_W = 18;

  // Reset values
  localparam logic [31:0] MASK_RESET = 32'h0000_0000;
  localparam logic [15:0] PHASE_SRC_RESET = 16'h0000;
  localparam logic [31:0] STATUS_RESET = 32'h0000_0000;
  localparam logic [31:0] ZERO_WORD = 32'h0000_0000;

  // Writable bits of the two masks and used bits of the phase source register
  localparam logic [31:0] MASK_WRITABLE = 32'h039F_FFFF;
  localparam logic [31:0] COMP_MASK_WRITABLE = 32'h0002_0000;
  localparam logic [15:0] PHASE_SRC_USED = 16'h7E38;

  // Bit positions in the mask and the second status register
  localparam int BIT_NOLOAD_TOTAL = 0;
  localparam int BIT_NOLOAD_FUND = 1;
  localparam int BIT_NOLOAD_APP = 2;
  localparam int BIT_VOLT_TIMEOUT = 3;
  localparam int BIT_CURR_TIMEOUT = 6;
  localparam int BIT_VOLT_CROSS = 9;
  localparam int BIT_CURR_CROSS = 12;
  localparam int BIT_RESET_DONE = 15;
  localparam int BIT_SAG = 16;
  localparam int BIT_OVERCURRENT = 17;
  localparam int BIT_OVERVOLTAGE = 18;
  localparam int BIT_PHASE_ORDER = 19;
  localparam int BIT_MISMATCH = 20;
  localparam int BIT_CURR_PEAK = 23;
  localparam int BIT_VOLT_PEAK = 24;
  localparam int BIT_SIGNATURE = 25;

  // Companion register bit
  localparam int BIT_DSP_DONE = 17;

  // Bit positions in the phase source register
  localparam int SRC_OVERCURRENT = 3;
  localparam int SRC_OVERVOLTAGE = 9;
  localparam int SRC_SAG = 12;

  // Event pulses from the detectors, one cycle each
  typedef struct packed {
    logic noloadTotal;
    logic noloadFund;
    logic noloadApparent;
    logic [2:0] voltTimeout;
    logic [2:0] currTimeout;
    logic [2:0] voltCross;
    logic [2:0] currCross;
    logic sag;
    logic overcurrent;
    logic overvoltage;
    logic phaseOrder;
    logic mismatch;
    logic currPeakEnd;
    logic voltPeakEnd;
    logic signatureChange;
    logic dspCycleDone;
    logic [2:0] sagPhase;
    logic [2:0] overcurrentPhase;
    logic [2:0] overvoltagePhase;
  } event_in_t;

  // Avalon-MM slave request
  typedef struct packed {
    logic [ADDR_W-1:0] address;
    logic read;
    logic write;
    logic [31:0] writedata;
    logic [3:0] byteenable;
  } avmm_req_t;

endpackage

// *** testbench.sv ***
// Self-checking testbench for the event interrupt mask block
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import meter_irq_pkg::*;
  logic mclk;
  logic resetn;
  logic clkEn;
  avmm_req_t busReq;
  event_in_t events;
  logic [31:0] readdata;
  logic waitrequest;
  logic irq;
  logic [31:0] rdVal;
  int bad_count = 0;
  int checks_done = 0;
  int cycleCount = 0;
  int bitList[23] = '{0, 1, 2, 3, 4, 5, 6, 7, 8, 9, 10, 11, 12, 13, 14, 16, 17, 18, 19, 20, 23, 24, 25};

  meter_event_interrupt_mask dut (.mclk(mclk), .resetn(resetn), .clkEn(clkEn), .busReq(busReq),
    .readdata(readdata), .waitrequest(waitrequest), .events(events), .irq(irq));

  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  task automatic final_report();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  always @(posedge mclk) begin
    cycleCount <= cycleCount + 1;
    if (cycleCount == 5000) begin
      bad_count++;
      final_report();
    end
  end

  task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // One Avalon access, held until waitrequest is sampled low at a rising edge
  task automatic bus_op(input logic isWrite, input logic [15:0] idx, input logic [31:0] data);
    int n;
    n = 0;
    busReq <= '{address: {idx, 2'b00}, read: ~isWrite, write: isWrite, writedata: data, byteenable: 4'hF};
    @(posedge mclk);
    while (waitrequest !== 1'b0) begin
      @(posedge mclk);
      n++;
    end
    rdVal = readdata;
    chk("bus wait", 32'(n), 32'h0000_0001);
    busReq <= '{default: '0};
    @(posedge mclk);
  endtask

  task automatic rd_chk(input string what, input logic [15:0] idx, input logic [31:0] exp);
    bus_op(1'b0, idx, 32'h0000_0000);
    chk(what, rdVal, exp);
  endtask

  task automatic irq_chk(input logic exp);
    @(posedge mclk);
    @(negedge mclk);
    chk("irq", {31'h0000_0000, irq}, {31'h0000_0000, exp});
    @(posedge mclk);
  endtask

  task automatic pulse(input event_in_t ev);
    events <= ev;
    @(posedge mclk);
    events <= '0;
    @(posedge mclk);
    @(posedge mclk);
  endtask

  function automatic event_in_t ev_for(input int b);
    event_in_t e;
    e = '0;
    case (b)
      0: e.noloadTotal = 1'b1;
      1: e.noloadFund = 1'b1;
      2: e.noloadApparent = 1'b1;
      3, 4, 5: e.voltTimeout[b-3] = 1'b1;
      6, 7, 8: e.currTimeout[b-6] = 1'b1;
      9, 10, 11: e.voltCross[b-9] = 1'b1;
      12, 13, 14: e.currCross[b-12] = 1'b1;
      16: e = '{sag: 1'b1, sagPhase: 3'h1, default: '0};
      17: e = '{overcurrent: 1'b1, overcurrentPhase: 3'h1, default: '0};
      18: e = '{overvoltage: 1'b1, overvoltagePhase: 3'h1, default: '0};
      19: e.phaseOrder = 1'b1;
      20: e.mismatch = 1'b1;
      23: e.currPeakEnd = 1'b1;
      24: e.voltPeakEnd = 1'b1;
      default: e.signatureChange = 1'b1;
    endcase
    return e;
  endfunction

  initial begin
    resetn = 1'b0;
    clkEn = 1'b1;
    busReq = '{default: '0};
    events = '0;
    repeat (6) @(posedge mclk);
    resetn <= 1'b1;
    @(posedge mclk);
    // Reset complete, mask reset and write mask
    irq_chk(1'b1);
    rd_chk("status", STATUS_INDEX, 32'h0000_8000);
    rd_chk("mask", MASK_INDEX, 32'h0000_0000);
    bus_op(1'b1, STATUS_INDEX, 32'h0000_8000);
    irq_chk(1'b0);
    bus_op(1'b1, MASK_INDEX, 32'hFFFF_FFFF);
    rd_chk("mask", MASK_INDEX, 32'h039F_FFFF);
    irq_chk(1'b0);
    $display("test reset and mask done");
    // Every detector event except dspCycleDone: latch unmasked, then gate irq by its mask bit
    foreach (bitList[i]) begin
      bus_op(1'b1, MASK_INDEX, 32'h0000_0000);
      pulse(ev_for(bitList[i]));
      rd_chk("status", STATUS_INDEX, 32'h0000_0001 << bitList[i]);
      irq_chk(1'b0);
      bus_op(1'b1, MASK_INDEX, 32'h0000_0001 << bitList[i]);
      irq_chk(1'b1);
      bus_op(1'b1, STATUS_INDEX, 32'h0000_0001 << bitList[i]);
      irq_chk(1'b0);
    end
    $display("test event gating done");
    // Phase source bits per event and phase
    pulse('{sag: 1'b1, sagPhase: 3'h2, overcurrent: 1'b1, overcurrentPhase: 3'h4,
      overvoltage: 1'b1, overvoltagePhase: 3'h1, default: '0});
    bus_op(1'b1, PHASE_SRC_INDEX, 32'h0000_FFFF);
    rd_chk("phase source", PHASE_SRC_INDEX, 32'h0000_2220);
    bus_op(1'b1, STATUS_INDEX, 32'h0001_0000);
    rd_chk("phase source", PHASE_SRC_INDEX, 32'h0000_0220);
    bus_op(1'b1, STATUS_INDEX, 32'h0006_0000);
    rd_chk("phase source", PHASE_SRC_INDEX, 32'h0000_0000);
    // Sag arriving in the clearing cycle wins over the clear
    pulse('{sag: 1'b1, sagPhase: 3'h1, default: '0});
    fork
      bus_op(1'b1, STATUS_INDEX, 32'h0001_0000);
      begin
        @(posedge mclk);
        events <= '{sag: 1'b1, sagPhase: 3'h4, default: '0};
        @(posedge mclk);
        events <= '0;
      end
    join
    rd_chk("status", STATUS_INDEX, 32'h0001_0000);
    rd_chk("phase source", PHASE_SRC_INDEX, 32'h0000_4000);
    bus_op(1'b1, STATUS_INDEX, 32'h0001_0000);
    rd_chk("phase source", PHASE_SRC_INDEX, 32'h0000_0000);
    $display("test phase source done");
    // Companion mask and unmapped address
    bus_op(1'b1, COMP_MASK_INDEX, 32'hFFFF_FFFF);
    rd_chk("companion mask", COMP_MASK_INDEX, 32'h0002_0000);
    pulse('{dspCycleDone: 1'b1, default: '0});
    irq_chk(1'b1);
    bus_op(1'b1, COMP_STATUS_INDEX, 32'h0002_0000);
    irq_chk(1'b0);
    bus_op(1'b1, 16'h0040, 32'hFFFF_FFFF);
    rd_chk("unmapped", 16'h0040, 32'h0000_0000);
    $display("test companion and unmapped done");
    // Clock enable low: an event is not captured
    clkEn <= 1'b0;
    pulse('{voltCross: 3'h1, default: '0});
    clkEn <= 1'b1;
    rd_chk("frozen status", STATUS_INDEX, 32'h0000_0000);
    $display("test clock enable done");
    final_report();
  end
endmodule
`default_nettype wire
